// *** hadp_pkg.sv ***
package hadp_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CODE_W = 2;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Host function codes
    localparam logic [1:0] CODE_IDLE = 2'h3;
    localparam logic [1:0] CODE_MEMORY = 2'h2;
    localparam logic [1:0] CODE_REGISTER = 2'h1;
    localparam logic [1:0] CODE_GENERAL = 2'h0;

    // ==========================================================
    // Address layout for register-type accesses
    localparam int SLAVE_SPACE_BIT = 12;
    localparam logic [11:0] SLAVE_SELECT_LAST = 12'h003;

    // ==========================================================
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        HADP_IDLE = 2'b00,
        HADP_DECODE = 2'b01,
        HADP_WAIT = 2'b10,
        HADP_DONE = 2'b11
    } hadp_state_e;

    typedef struct packed {
        hadp_state_e state;
        logic [CODE_W-1:0] code;
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic wrStrobe;
        logic [DATA_W-1:0] wrData;
        logic intOut;
        logic intOe;
    } hadp_port_s;

    localparam hadp_port_s PORT_RESET = '{
        state: HADP_IDLE,
        code: CODE_IDLE,
        addr: ADDR_RESET,
        rd: 1'b1,
        dout: DATA_RESET,
        doe: 1'b0,
        wrStrobe: 1'b0,
        wrData: DATA_RESET,
        intOut: 1'b0,
        intOe: 1'b0
    };

endpackage : hadp_pkg

// *** hadp_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module hadp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] asyncIn,
    input wire logic [WIDTH-1:0] resetValue,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    // ==========================================================
    // Two flops per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stage1[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else begin
                    stage1[i] <= asyncIn[i] ^ resetValue[i];
                    syncOut[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : hadp_sync

`default_nettype wire

// *** hadp_irq_combine.sv ***
`timescale 1ns/100ps
`default_nettype none

module hadp_irq_combine #(
    parameter int SOURCES = 4
) (
    input wire logic [SOURCES-1:0] irqRequest,
    input wire logic [SOURCES-1:0] irqEnable,
    output logic anyEnabled
);

    // OR of every enabled request
    assign anyEnabled = |(irqRequest & irqEnable); // [RULE8]

endmodule : hadp_irq_combine

`default_nettype wire

// *** hadp_host_access_decode_port.sv ***
`timescale 1ns/100ps
`default_nettype none

// Function
// [RULE1] Function code 11 is idle, 10 local memory, 01 registers or slave, 00 external PROMs.
// [RULE2] The function code comes in asynchronously and is synchronised before decoding.
// [RULE3] The host drives the read strobe low for reads and high for writes.
// [RULE4] Host ready rises once the target can take write data or has read data ready.
// [RULE5] With the code idle, host ready floats in normal mode and is driven high in pipeline.
// [RULE6] The low lane enable joins the low bytes, in pipeline only in non-memory cycles.
// [RULE7] The high lane enable joins the high bytes, in pipeline it opens the memory latch.
// [RULE8] The interrupt output is the OR of all enabled interrupt requests.
// [RULE9] After reset the interrupt output floats until it is set to drive.
// [RULE10] The general select goes low when the code asks for external PROMs or latches.
// [RULE11] Reset returns all logic to a defined passive state.
// [RULE12] The 13 address lines pick a register or a memory location by access type.
// [RULE13] The data bus is driven only for internal register reads or in tightly coupled mode.
// [RULE14] The slave select is asserted for locations 0 to 3 of the slave space.
// [RULE15] The host holds code, address and strobe until ready, then returns the code to idle.
module hadp_host_access_decode_port #(
    parameter int IRQ_SOURCES = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] hostFunctionCode,
    input wire logic hostReadStrobeN,
    input wire logic [12:0] hostAddr,
    input wire logic [7:0] hostDataIn,
    input wire logic pipelineMode,
    input wire logic tightlyCoupledMode,
    input wire logic [7:0] tightlyCoupledData,
    input wire logic targetReady,
    input wire logic [7:0] regReadData,
    input wire logic [IRQ_SOURCES-1:0] irqRequest,
    input wire logic [IRQ_SOURCES-1:0] irqEnable,
    input wire logic intDriveEnable,
    output logic hostReadyOut,
    output logic hostReadyOe,
    output logic lowLaneXcvrEnable,
    output logic highLaneXcvrEnable,
    output logic generalSelectN,
    output logic slaveSelectN,
    output logic interruptOut,
    output logic interruptOe,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic memAccess,
    output logic regAccess,
    output logic targetRequest,
    output logic accessRead,
    output logic [12:0] targetAddr,
    output logic regWriteStrobe,
    output logic [7:0] regWriteData
);

    localparam int IN_W = hadp_pkg::CODE_W + 1 + hadp_pkg::ADDR_W + hadp_pkg::DATA_W;
    localparam logic [IN_W-1:0] IN_RESET = {hadp_pkg::CODE_IDLE, 1'b1, 21'h00000};

    hadp_pkg::hadp_port_s st;
    hadp_pkg::hadp_port_s next_st;
    logic [IN_W-1:0] syncRaw;
    logic [1:0] syncCode;
    logic syncRdN;
    logic [12:0] syncAddr;
    logic [7:0] syncData;
    logic anyIrq;
    logic active;
    logic isMem;
    logic isReg;
    logic isGen;
    logic isSlave;
    logic internalReg;

    // ==========================================================
    // Input synchronisers
    hadp_sync #(
        .WIDTH(IN_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({hostFunctionCode, hostReadStrobeN, hostAddr, hostDataIn}), // [RULE2]
        .resetValue(IN_RESET),
        .syncOut(syncRaw)
    );

    // Sync flops reset to zero; restore the idle levels
    assign {syncCode, syncRdN, syncAddr, syncData} = syncRaw ^ IN_RESET;

    hadp_irq_combine #(
        .SOURCES(IRQ_SOURCES)
    ) u_irq (
        .irqRequest(irqRequest),
        .irqEnable(irqEnable),
        .anyEnabled(anyIrq)
    );

    // ==========================================================
    // Access type decode from the captured code
    assign active = (st.state != hadp_pkg::HADP_IDLE);
    assign isMem = active && (st.code == hadp_pkg::CODE_MEMORY); // [RULE1]
    assign isReg = active && (st.code == hadp_pkg::CODE_REGISTER); // [RULE1]
    assign isGen = active && (st.code == hadp_pkg::CODE_GENERAL); // [RULE1]
    // Address is only captured on leaving decode
    assign isSlave = isReg && (st.state != hadp_pkg::HADP_DECODE) && st.addr[hadp_pkg::SLAVE_SPACE_BIT]; // [RULE12]
    assign internalReg = isReg && !st.addr[hadp_pkg::SLAVE_SPACE_BIT]; // [RULE12]

    // ==========================================================
    // Sequencer
    always_comb begin
        next_st = st;
        next_st.wrStrobe = 1'b0;
        next_st.doe = 1'b0;
        next_st.intOut = anyIrq; // [RULE8]
        // Interrupt pin floats until enabled to drive
        next_st.intOe = intDriveEnable; // [RULE9]
        unique case (st.state)
            hadp_pkg::HADP_IDLE: begin
                if (syncCode != hadp_pkg::CODE_IDLE) begin
                    next_st.state = hadp_pkg::HADP_DECODE;
                    next_st.code = syncCode;
                end
            end
            hadp_pkg::HADP_DECODE: begin
                // Code must read the same twice to rule out a skewed edge
                if (syncCode != st.code) begin // [RULE2]
                    next_st.state = hadp_pkg::HADP_IDLE;
                    next_st.code = hadp_pkg::CODE_IDLE;
                end else begin
                    next_st.state = hadp_pkg::HADP_WAIT;
                    next_st.addr = syncAddr; // [RULE12]
                    next_st.rd = syncRdN; // [RULE3]
                    next_st.wrData = syncData;
                end
            end
            hadp_pkg::HADP_WAIT: begin
                // Internal registers answer at once, others wait on the target
                if (internalReg || targetReady) begin // [RULE4]
                    next_st.state = hadp_pkg::HADP_DONE;
                    if (internalReg && !st.rd) begin
                        next_st.dout = regReadData;
                        next_st.doe = 1'b1; // [RULE13]
                    end
                    if (internalReg && st.rd) begin
                        next_st.wrStrobe = 1'b1;
                    end
                end
            end
            hadp_pkg::HADP_DONE: begin
                // Hold ready until the host drops the code to idle
                if (syncCode == hadp_pkg::CODE_IDLE) begin
                    next_st.state = hadp_pkg::HADP_IDLE;
                    next_st.code = hadp_pkg::CODE_IDLE;
                end else begin
                    // Read data stands until the host lets go
                    next_st.doe = internalReg && !st.rd; // [RULE13]
                end
            end
        endcase
        if (tightlyCoupledMode) begin
            next_st.dout = tightlyCoupledData;
            next_st.doe = 1'b1; // [RULE13]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= hadp_pkg::PORT_RESET; // [RULE11]
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Pin outputs
    assign hostReadyOut = (st.state == hadp_pkg::HADP_DONE) || !active; // [RULE4]
    assign hostReadyOe = active || pipelineMode; // [RULE5]
    assign lowLaneXcvrEnable = active && (!pipelineMode || !isMem); // [RULE6]
    assign highLaneXcvrEnable = isMem; // [RULE7]
    assign generalSelectN = !isGen; // [RULE10]
    assign slaveSelectN = !(isSlave && (st.addr[11:0] <= hadp_pkg::SLAVE_SELECT_LAST)); // [RULE14]
    assign interruptOut = st.intOut;
    assign interruptOe = st.intOe;
    assign dataOut = st.dout;
    assign dataOe = st.doe;
    assign memAccess = isMem && (st.state != hadp_pkg::HADP_DECODE);
    assign regAccess = internalReg && (st.state != hadp_pkg::HADP_DECODE);
    assign targetRequest = (st.state == hadp_pkg::HADP_WAIT) && !internalReg;
    assign accessRead = !st.rd;
    assign targetAddr = st.addr;
    assign regWriteStrobe = st.wrStrobe;
    assign regWriteData = st.wrData;

    // ==========================================================
    // Checks
    chk_decode_needs_sync: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
        (st.state == hadp_pkg::HADP_DECODE && $past(st.state) == hadp_pkg::HADP_IDLE)
        |-> st.code == $past(hostFunctionCode, 3))
        else $error("decode entered without a synced request");
    chk_ready_after_target: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        (st.state == hadp_pkg::HADP_WAIT && !internalReg && targetReady)
        |=> hostReadyOut && hostReadyOe)
        else $error("host ready missing after target ready");
    chk_ready_low_waiting: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        (st.state == hadp_pkg::HADP_WAIT) |-> !hostReadyOut)
        else $error("host ready raised while waiting");
    chk_idle_ready_pin: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
        !active |-> (hostReadyOe == pipelineMode) && hostReadyOut)
        else $error("idle host ready drive wrong");
    chk_low_lane_pipe: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
        (pipelineMode && isMem) |-> !lowLaneXcvrEnable)
        else $error("low lane open in pipelined memory cycle");
    chk_high_lane_mem: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
        highLaneXcvrEnable |-> st.code == hadp_pkg::CODE_MEMORY && active)
        else $error("high lane open outside memory cycle");
    chk_irq_or: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
        $past(resetn) |-> interruptOut == $past(|(irqRequest & irqEnable)))
        else $error("interrupt output not the enabled OR");
    chk_irq_float: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
        !$past(intDriveEnable) |-> !interruptOe)
        else $error("interrupt driven without enable");
    chk_general_select: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
        !generalSelectN |-> active && st.code == hadp_pkg::CODE_GENERAL)
        else $error("general select outside external access");
    chk_data_drive: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
        dataOe |-> $past(tightlyCoupledMode) || (internalReg && !st.rd))
        else $error("data bus driven outside register read");
    chk_slave_range: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        !slaveSelectN |-> isSlave && st.addr[11:2] == 10'h000)
        else $error("slave select outside locations 0 to 3");
    chk_done_held: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        (st.state == hadp_pkg::HADP_DONE && syncCode != hadp_pkg::CODE_IDLE)
        |=> st.state == hadp_pkg::HADP_DONE)
        else $error("ready dropped before code went idle");

    // ==========================================================
    // Decode, answer and pin checks
    chk_skew_dropped: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
        (st.state == hadp_pkg::HADP_DECODE && syncCode != st.code)
        |=> st.state == hadp_pkg::HADP_IDLE)
        else $error("skewed code not dropped");
    chk_target_wait: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        (st.state == hadp_pkg::HADP_WAIT && !internalReg && !targetReady)
        |=> st.state == hadp_pkg::HADP_WAIT && !hostReadyOut)
        else $error("host ready raised before target ready");
    chk_reg_answer: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        (st.state == hadp_pkg::HADP_WAIT && internalReg)
        |=> st.state == hadp_pkg::HADP_DONE && hostReadyOut)
        else $error("register access not answered");
    chk_busy_ready_drive: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
        active
        |-> hostReadyOe)
        else $error("host ready floating during access");
    chk_low_lane_open: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
        (active && !(pipelineMode && st.code == hadp_pkg::CODE_MEMORY))
        |-> lowLaneXcvrEnable)
        else $error("low lane closed during access");
    chk_high_lane_open: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
        (active && st.code == hadp_pkg::CODE_MEMORY)
        |-> highLaneXcvrEnable)
        else $error("high lane closed in memory cycle");
    chk_general_open: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
        (active && st.code == hadp_pkg::CODE_GENERAL)
        |-> !generalSelectN)
        else $error("general select missing");
    chk_slave_open: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        (isReg && st.state != hadp_pkg::HADP_DECODE && st.addr[12:2] == 11'h400)
        |-> !slaveSelectN)
        else $error("slave select missing for locations 0 to 3");
    chk_write_pulse: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
        regWriteStrobe
        |-> regAccess && !accessRead && st.state == hadp_pkg::HADP_DONE)
        else $error("register write outside a write access");
    chk_read_data: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
        (st.state == hadp_pkg::HADP_WAIT && internalReg && !st.rd && !tightlyCoupledMode)
        |=> dataOe && dataOut == $past(regReadData))
        else $error("register read data not driven");
    chk_irq_drive: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
        ($past(resetn) && $past(intDriveEnable))
        |-> interruptOe)
        else $error("interrupt not driven when enabled");
    chk_idle_passive: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
        !active
        |-> !lowLaneXcvrEnable && !highLaneXcvrEnable && generalSelectN && slaveSelectN)
        else $error("idle outputs not passive");

    cov_mem_access: cover property (@(posedge clk) disable iff (!resetn)
        isMem ##1 (st.state == hadp_pkg::HADP_DONE));
    cov_reg_read: cover property (@(posedge clk) disable iff (!resetn)
        internalReg && dataOe);
    cov_slave_select: cover property (@(posedge clk) disable iff (!resetn)
        !slaveSelectN && hostReadyOut);
    cov_general_write: cover property (@(posedge clk) disable iff (!resetn)
        !generalSelectN && st.rd && hostReadyOut);
    cov_pipe_latch: cover property (@(posedge clk) disable iff (!resetn)
        highLaneXcvrEnable && pipelineMode && !lowLaneXcvrEnable);

endmodule : hadp_host_access_decode_port

`default_nettype wire

// *** hadp_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module hadp_host_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [1:0] reqCode,
    input wire logic reqRead,
    input wire logic [12:0] reqAddr,
    input wire logic [7:0] reqData,
    input wire logic hostReadyOut,
    input wire logic hostReadyOe,
    output logic [1:0] hostFunctionCode,
    output logic hostReadStrobeN,
    output logic [12:0] hostAddr,
    output logic [7:0] hostDataIn,
    output logic busy
);
    int phase;
    int cnt;

    // ==========================================================
    // Host cycle sequencer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hostFunctionCode <= hadp_pkg::CODE_IDLE;
            hostReadStrobeN <= 1'b1;
            hostAddr <= 13'h0000;
            hostDataIn <= 8'h00;
            busy <= 1'b0;
            phase <= 0;
            cnt <= 0;
        end else begin
            case (phase)
                0: if (start) begin
                    hostFunctionCode <= reqCode;
                    hostReadStrobeN <= !reqRead;
                    hostAddr <= reqAddr;
                    hostDataIn <= reqData;
                    busy <= 1'b1;
                    cnt <= 0;
                    phase <= 1;
                end
                // Ready drops once the access is decoded; a floating pin is not low
                1: if (hostReadyOe && !hostReadyOut) phase <= 2;
                // Everything held until ready, then released
                2: if (hostReadyOe && hostReadyOut) begin
                    hostFunctionCode <= hadp_pkg::CODE_IDLE;
                    hostAddr <= ~hostAddr;
                    hostDataIn <= ~hostDataIn;
                    hostReadStrobeN <= ~hostReadStrobeN;
                    phase <= 3;
                end
                // Idle gap before the next access
                default: begin
                    cnt <= cnt + 1;
                    if (cnt == 5) begin
                        busy <= 1'b0;
                        phase <= 0;
                    end
                end
            endcase
        end
    end
endmodule : hadp_host_model

`default_nettype wire

// *** hadp_host_access_decode_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module hadp_host_access_decode_port_tb;
    logic clk = 0, resetn = 0, pipe = 0, tcm = 0, tReady = 0, intDrv = 0, start = 0, rdReq = 0;
    logic [1:0] code, reqCode = 2'h3;
    logic rdN, busy, rdyOut, rdyOe, lowEn, highEn, genN, slvN, intOut, intOe, dOe;
    logic memAcc, regAcc, tReq, accRd, wrStb;
    logic [12:0] addr, tAddr, reqAddr = 13'h0000;
    logic [13:0] capAddr;
    logic [7:0] din, dOut, wrData, capRd, capWr, tcData = 8'h00, regRd = 8'h5a, reqData = 8'h00;
    logic [3:0] irqReq = 4'h0, irqEn = 4'h0;
    logic [5:0] seen;
    int n_mismatch = 0, checks = 0, wcnt = 0;

    always #50 clk = ~clk;

    hadp_host_model i_hadp_host_model (.clk(clk), .resetn(resetn), .start(start),
        .reqCode(reqCode), .reqRead(rdReq), .reqAddr(reqAddr), .reqData(reqData),
        .hostReadyOut(rdyOut), .hostReadyOe(rdyOe), .hostFunctionCode(code),
        .hostReadStrobeN(rdN), .hostAddr(addr), .hostDataIn(din), .busy(busy));

    hadp_host_access_decode_port #(.IRQ_SOURCES(4)) i_hadp_host_access_decode_port (
        .clk(clk), .resetn(resetn), .hostFunctionCode(code), .hostReadStrobeN(rdN),
        .hostAddr(addr), .hostDataIn(din), .pipelineMode(pipe), .tightlyCoupledMode(tcm),
        .tightlyCoupledData(tcData), .targetReady(tReady), .regReadData(regRd),
        .irqRequest(irqReq), .irqEnable(irqEn), .intDriveEnable(intDrv),
        .hostReadyOut(rdyOut), .hostReadyOe(rdyOe), .lowLaneXcvrEnable(lowEn),
        .highLaneXcvrEnable(highEn), .generalSelectN(genN), .slaveSelectN(slvN),
        .interruptOut(intOut), .interruptOe(intOe), .dataOut(dOut), .dataOe(dOe),
        .memAccess(memAcc), .regAccess(regAcc), .targetRequest(tReq), .accessRead(accRd),
        .targetAddr(tAddr), .regWriteStrobe(wrStb), .regWriteData(wrData));

    // ==========================================================
    // Slow local target and access monitor
    always @(posedge clk) begin
        wcnt <= tReq ? wcnt + 1 : 0;
        tReady <= tReq && wcnt >= 3;
        if (busy) begin
            seen <= seen | {lowEn, highEn, !genN, !slvN, wrStb, dOe};
            if (wrStb) capWr <= wrData;
            if (dOe && rdyOut) capRd <= dOut;
            if (memAcc || regAcc || tReq) capAddr <= {accRd, tAddr};
        end
    end

    // ==========================================================
    // Reporting
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Scenarios
    task automatic access(input string nm, input logic p, input logic [1:0] c, input logic r,
        input logic [12:0] a, input logic [7:0] d, input logic [5:0] exp, input logic [7:0] expD);
        int n;
        n = 0;
        @(posedge clk);
        seen = 6'h00;
        capRd = 8'h00;
        capWr = 8'h00;
        capAddr = 14'h0000;
        pipe <= p;
        reqCode <= c;
        rdReq <= r;
        reqAddr <= a;
        reqData <= d;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected done seen timeout", nm);
            give_verdict();
        end
        check({nm, " lanes"}, 16'(seen), 16'(exp));
        check({nm, " addr"}, 16'(capAddr), 16'({r, a}));
        check({nm, " data"}, 16'(r ? capRd : capWr), 16'(expD));
        check({nm, " idle ready"}, 16'({rdyOe, rdyOe & rdyOut}), p ? 16'h3 : 16'h0);
        $display("test %s done", nm);
    endtask : access

    task automatic settle_check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(nm, got, exp);
    endtask : settle_check

    task automatic irq_test;
        @(posedge clk);
        irqReq <= 4'h5;
        irqEn <= 4'h4;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("irq undriven", 16'({intOe, intOut}), 16'h1);
        @(posedge clk);
        irqEn <= 4'ha;
        intDrv <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("irq masked", 16'({intOe, intOut}), 16'h2);
        @(posedge clk);
        irqReq <= 4'h8;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("irq top source", 16'({intOe, intOut}), 16'h3);
        $display("test irq done");
    endtask : irq_test

    task automatic tcm_test;
        @(posedge clk);
        tcData <= 8'hc3;
        tcm <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("coupled drive", 16'({dOe, dOut}), 16'h1c3);
        @(posedge clk);
        tcm <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("coupled off", 16'(dOe), 16'h0);
        $display("test coupled done");
    endtask : tcm_test

    task automatic reset_test;
        @(posedge clk);
        pipe <= 1'b0;
        reqCode <= hadp_pkg::CODE_GENERAL;
        rdReq <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("before reset", 16'({genN, busy}), 16'h1);
        @(posedge clk);
        resetn <= 1'b0;
        @(negedge clk);
        check("mid reset", 16'({genN, lowEn, rdyOe, intOe, dOe, busy}), 16'h20);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        $display("test mid reset done");
    endtask : reset_test

    initial begin
        repeat (20) @(negedge clk);
        check("reset", 16'({rdyOe, lowEn, highEn, genN, slvN, intOe, intOut, dOe, wrStb}),
            16'h030);
        @(posedge clk);
        resetn <= 1'b1;
        $display("test reset done");
        access("reg read", 0, hadp_pkg::CODE_REGISTER, 1, 13'h0005, 8'h00, 6'h21, 8'h5a);
        access("reg write", 0, hadp_pkg::CODE_REGISTER, 0, 13'h0007, 8'ha5, 6'h22, 8'ha5);
        access("slave out", 0, hadp_pkg::CODE_REGISTER, 1, 13'h1004, 8'h00, 6'h20, 8'h00);
        access("slave in", 0, hadp_pkg::CODE_REGISTER, 0, 13'h1003, 8'h66, 6'h24, 8'h00);
        access("mem normal", 0, hadp_pkg::CODE_MEMORY, 1, 13'h0abc, 8'h00, 6'h30, 8'h00);
        access("mem pipe", 1, hadp_pkg::CODE_MEMORY, 0, 13'h1fff, 8'h33, 6'h10, 8'h00);
        access("general pipe", 1, hadp_pkg::CODE_GENERAL, 1, 13'h0012, 8'h00, 6'h28, 8'h00);
        irq_test();
        tcm_test();
        reset_test();
        access("after reset", 0, hadp_pkg::CODE_REGISTER, 1, 13'h0002, 8'h00, 6'h21, 8'h5a);
        give_verdict();
    end
endmodule : hadp_host_access_decode_port_tb

`default_nettype wire
